// ---- hw/vatd_core.sv ----
// Frame back end of the voice activity detector with downlink tone detection
`timescale 1ns/10ps
`include "vatd_map.svh"
module vatd_core #(
  parameter logic signed [15:0] FREQ_COEF = `VATD_FREQ_COEF
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire vatd_pkg::vatd_wb_req_t wb_req,
  output logic [31:0] wb_rdata,
  output logic wb_ack,
  output vatd_pkg::vatd_flags_t flags
);
  import vatd_pkg::*;

  localparam logic [15:0] HANN [0:79] = '{
    16'h0000, 16'h000c, 16'h0033, 16'h0072, 16'h00cc, 16'h013e, 16'h01ca, 16'h026e,
    16'h032b, 16'h0401, 16'h04ee, 16'h05f3, 16'h070f, 16'h0842, 16'h098c, 16'h0aeb,
    16'h0c5f, 16'h0de8, 16'h0f84, 16'h1135, 16'h12f8, 16'h14cd, 16'h16b3, 16'h18aa,
    16'h1ab0, 16'h1cc5, 16'h1ee9, 16'h2119, 16'h2356, 16'h259f, 16'h27f2, 16'h2a4f,
    16'h2cb4, 16'h2f21, 16'h3195, 16'h340e, 16'h368c, 16'h390f, 16'h3b93, 16'h3e1a,
    16'h40a1, 16'h4328, 16'h45ae, 16'h4832, 16'h4ab2, 16'h4d2e, 16'h4fa5, 16'h5216,
    16'h547f, 16'h56e0, 16'h5938, 16'h5b86, 16'h5dc9, 16'h5fff, 16'h622a, 16'h6446,
    16'h6654, 16'h6853, 16'h6a41, 16'h6c1f, 16'h6deb, 16'h6fa5, 16'h714b, 16'h72de,
    16'h745d, 16'h75c7, 16'h771b, 16'h7859, 16'h7981, 16'h7a91, 16'h7b8a, 16'h7c6c,
    16'h7d35, 16'h7de6, 16'h7e7e, 16'h7efd, 16'h7f63, 16'h7fb0, 16'h7fe3, 16'h7ffc
  };

  // Saturating fixed-point helpers
  function automatic logic signed [15:0] sat16(input logic signed [31:0] x);
    if (x > 32'sh0000_7fff) return 16'sh7fff;
    if (x < -32'sh0000_8000) return -16'sh8000;
    return x[15:0];
  endfunction

  function automatic logic signed [15:0] add16(input logic signed [15:0] a,
                                               input logic signed [15:0] b);
    logic signed [31:0] ea;
    logic signed [31:0] eb;
    ea = a;
    eb = b;
    return sat16(ea + eb);
  endfunction

  function automatic logic signed [15:0] mult_r(input logic signed [15:0] a,
                                                input logic signed [15:0] b);
    logic signed [31:0] ea;
    logic signed [31:0] eb;
    ea = a;
    eb = b;
    return sat16((ea * eb + 32'sh0000_4000) >>> 15);
  endfunction

  function automatic logic signed [15:0] mult_t(input logic signed [15:0] a,
                                                input logic signed [15:0] b);
    logic signed [31:0] ea;
    logic signed [31:0] eb;
    ea = a;
    eb = b;
    return sat16((ea * eb) >>> 15);
  endfunction

  function automatic logic signed [31:0] l_mult(input logic signed [15:0] a,
                                                input logic signed [15:0] b);
    logic signed [31:0] ea;
    logic signed [31:0] eb;
    logic signed [31:0] p;
    ea = a;
    eb = b;
    p = ea * eb;
    if (p == 32'sh4000_0000) return 32'sh7fff_ffff;
    return p <<< 1;
  endfunction

  function automatic logic signed [31:0] l_add(input logic signed [31:0] a,
                                               input logic signed [31:0] b);
    logic signed [32:0] s;
    s = {a[31], a} + {b[31], b};
    if (s[32] != s[31]) return s[32] ? 32'sh8000_0000 : 32'sh7fff_ffff;
    return s[31:0];
  endfunction

  function automatic logic signed [31:0] l_sub(input logic signed [31:0] a,
                                               input logic signed [31:0] b);
    logic signed [32:0] s;
    s = {a[31], a} - {b[31], b};
    if (s[32] != s[31]) return s[32] ? 32'sh8000_0000 : 32'sh7fff_ffff;
    return s[31:0];
  endfunction

  function automatic logic [4:0] norm32(input logic [31:0] x);
    logic [4:0] n;
    logic run;
    n = 5'h00;
    run = 1'b1;
    for (int i = 30; i >= 0; i--) begin
      if (run && x[i] == x[31]) begin
        n = n + 5'h01;
      end else begin
        run = 1'b0;
      end
    end
    return (x == 32'h0000_0000) ? 5'h00 : n;
  endfunction

  function automatic logic signed [15:0] div15(input logic signed [15:0] num,
                                               input logic signed [15:0] den);
    logic [16:0] r;
    logic [15:0] q;
    r = {1'b0, num};
    q = 16'h0000;
    for (int i = 0; i < 15; i++) begin
      q = {q[14:0], 1'b0};
      r = {r[15:0], 1'b0};
      if (r >= {1'b0, den}) begin
        r = r - {1'b0, den};
        q = q + 16'h0001;
      end
    end
    return (num == den) ? `VATD_MAX_Q15 : q;
  endfunction

  function automatic logic in_block(input logic [11:0] adr, input logic [11:0] base,
                                    input int n);
    return adr[11:2] >= base[11:2] && 32'(adr[11:2]) < 32'(base[11:2]) + n;
  endfunction

  // Bus and configuration state
  logic downlink_q;
  logic signed [15:0] pv_mant_q, pv_exp_q, th_mant_q, th_exp_q;
  logic [15:0] lags_q [0:3];
  logic [15:0] avg_pred_q [0:8];
  logic [15:0] ref_pred_q [0:8];
  logic [4:0] avg_shift_q, ref_shift_q;
  logic [3:0] adapt_count_q;
  logic [29:0] test_param_q;
  logic final_vad_q, speech_flag_q;
  logic signed [15:0] sof_q [0:159];
  // Processing state
  vatd_state_t state_q;
  logic signed [15:0] sofh_q [0:159];
  logic [7:0] idx_q;
  logic [2:0] lagk_q;
  logic [1:0] seg_q;
  logic [2:0] n_q;
  logic signed [31:0] acc_q;
  logic signed [31:0] acfh_q [0:4];
  logic signed [15:0] smax_q;
  logic signed [4:0] scal_q;
  logic signed [15:0] p_q [0:4];
  logic signed [15:0] k_q [2:4];
  logic signed [15:0] rc_q [1:4];
  logic [15:0] oldlag_q;
  logic [2:0] lagcount_q, oldlagcount_q, veryoldlagcount_q;

  logic req;
  logic [31:0] rd_word, wr_word;
  logic start_wr, thr_wr;
  logic [7:0] sidx;
  logic [3:0] aidx, ridx;

  assign req = wb_req.cyc & wb_req.stb & ~wb_ack;
  assign sidx = 8'(wb_req.adr[9:2]);
  assign aidx = 4'(wb_req.adr[5:2]);
  assign ridx = 4'(wb_req.adr[5:2]);
  assign start_wr = req & wb_req.we & wb_req.sel[0] & (wb_req.adr == `VATD_OFF_CTRL)
                    & wb_req.dat[`VATD_CTRL_START_BIT];
  assign thr_wr = req & wb_req.we & wb_req.sel[0] & (wb_req.adr == `VATD_OFF_CTRL)
                  & wb_req.dat[`VATD_CTRL_THR_UPDATE_BIT];

  always_comb begin
    rd_word = `VATD_RST_WORD;
    case (wb_req.adr)
      `VATD_OFF_CTRL: rd_word[`VATD_CTRL_DOWNLINK_BIT] = downlink_q;
      `VATD_OFF_STATUS: rd_word = {8'h00, adapt_count_q, 1'b0, veryoldlagcount_q, 1'b0,
                                   oldlagcount_q, 1'b0, lagcount_q, 4'h0, flags.periodicity,
                                   flags.tone, flags.activity, flags.busy};
      `VATD_OFF_PV_MANT: rd_word = {16'h0000, pv_mant_q};
      `VATD_OFF_PV_EXP: rd_word = {16'h0000, pv_exp_q};
      `VATD_OFF_TH_MANT: rd_word = {16'h0000, th_mant_q};
      `VATD_OFF_TH_EXP: rd_word = {16'h0000, th_exp_q};
      `VATD_OFF_LAGS01: rd_word = {lags_q[1], lags_q[0]};
      `VATD_OFF_LAGS23: rd_word = {lags_q[3], lags_q[2]};
      `VATD_OFF_AVG_SHIFT: rd_word = {27'h0, avg_shift_q};
      `VATD_OFF_REF_SHIFT: rd_word = {27'h0, ref_shift_q};
      `VATD_OFF_TEST_PARAM: rd_word = {1'b0, test_param_q[29:15], 1'b0, test_param_q[14:0]};
      `VATD_OFF_TEST_FLAGS: rd_word = {30'h0, speech_flag_q, final_vad_q};
      `VATD_OFF_TEST_OUT: rd_word = {speech_flag_q, test_param_q[29:15],
                                     final_vad_q, test_param_q[14:0]};
      `VATD_OFF_OLD_LAG: rd_word = {16'h0000, oldlag_q};
      default: begin
        if (in_block(wb_req.adr, `VATD_OFF_AVG_BASE, `VATD_PRED_TERMS)) begin
          rd_word = {16'h0000, avg_pred_q[aidx]};
        end else if (in_block(wb_req.adr, `VATD_OFF_REF_BASE, `VATD_PRED_TERMS)) begin
          rd_word = {16'h0000, ref_pred_q[ridx]};
        end else if (in_block(wb_req.adr, `VATD_OFF_SAMPLE_BASE, `VATD_FRAME_LEN)) begin
          rd_word = {16'h0000, sof_q[sidx]};
        end
      end
    endcase
    for (int b = 0; b < 4; b++) begin
      wr_word[8*b +: 8] = wb_req.sel[b] ? wb_req.dat[8*b +: 8] : rd_word[8*b +: 8];
    end
  end

  // One wait state: ack and read data come one edge after the request appears
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_ack <= 1'b0;
      wb_rdata <= `VATD_RST_WORD;
    end else begin
      wb_ack <= req;
      wb_rdata <= req ? rd_word : wb_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      downlink_q <= 1'b0;
      {pv_mant_q, pv_exp_q, th_mant_q, th_exp_q} <= {2{`VATD_RST_WORD}};
      lags_q <= '{default: `VATD_RST_LAG};
      avg_pred_q <= '{default: `VATD_RST_LAG};
      avg_shift_q <= 5'h00;
      test_param_q <= 30'h0;
      final_vad_q <= 1'b0;
      speech_flag_q <= 1'b0;
    end else if (req && wb_req.we) begin
      case (wb_req.adr)
        `VATD_OFF_CTRL: downlink_q <= wr_word[`VATD_CTRL_DOWNLINK_BIT];
        `VATD_OFF_PV_MANT: pv_mant_q <= wr_word[15:0];
        `VATD_OFF_PV_EXP: pv_exp_q <= wr_word[15:0];
        `VATD_OFF_TH_MANT: th_mant_q <= wr_word[15:0];
        `VATD_OFF_TH_EXP: th_exp_q <= wr_word[15:0];
        `VATD_OFF_LAGS01: {lags_q[1], lags_q[0]} <= wr_word;
        `VATD_OFF_LAGS23: {lags_q[3], lags_q[2]} <= wr_word;
        `VATD_OFF_AVG_SHIFT: avg_shift_q <= wr_word[4:0];
        `VATD_OFF_TEST_PARAM: test_param_q <= {wr_word[30:16], wr_word[14:0]};
        `VATD_OFF_TEST_FLAGS: {speech_flag_q, final_vad_q} <= wr_word[1:0];
        default: begin
          if (in_block(wb_req.adr, `VATD_OFF_AVG_BASE, `VATD_PRED_TERMS)) begin
            avg_pred_q[aidx] <= wr_word[15:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (req && wb_req.we && in_block(wb_req.adr, `VATD_OFF_SAMPLE_BASE, `VATD_FRAME_LEN)) begin
      sof_q[sidx] <= wr_word[15:0];
    end
  end

  // Reference snapshot; copies the predictor values as they stand before this write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ref_pred_q <= '{default: `VATD_RST_LAG};
      ref_shift_q <= 5'h00;
      adapt_count_q <= `VATD_RST_ADAPT;
    end else if (thr_wr) begin
      ref_pred_q <= avg_pred_q;
      ref_shift_q <= avg_shift_q;
      adapt_count_q <= `VATD_ADAPT_LOAD;
    end
  end

  // Periodicity step for the current sub-segment
  logic [15:0] cur_lag, min_lag, max_lag, small_lag, fold;
  logic lag_hit;
  always_comb begin
    cur_lag = lags_q[seg_q];
    min_lag = (oldlag_q > cur_lag) ? cur_lag : oldlag_q;
    max_lag = (oldlag_q > cur_lag) ? oldlag_q : cur_lag;
    small_lag = max_lag;
    for (int j = 0; j < `VATD_MOD_PASSES; j++) begin
      if (small_lag >= min_lag) begin
        small_lag = small_lag - min_lag;
      end
    end
    fold = min_lag - small_lag;
    if ($signed(fold) < $signed(small_lag)) begin
      small_lag = fold;
    end
    lag_hit = $signed(small_lag) < `VATD_LAG_NEAR;
  end

  // Windowing, scaling and Schur step values
  logic [6:0] hidx;
  logic signed [15:0] win_s, win_abs, sc_a, sc_b, abs_p1, rc_now;
  logic signed [31:0] prod, shifted;
  logic [4:0] acf_norm;
  always_comb begin
    hidx = (idx_q < 8'(`VATD_HALF_LEN)) ? 7'(idx_q) : 7'(`VATD_LAST_SAMPLE - idx_q);
    win_s = mult_r(sof_q[idx_q], HANN[hidx]);
    win_abs = (win_s == -16'sh8000) ? `VATD_MAX_Q15 : (win_s[15] ? -win_s : win_s);
    sc_a = sofh_q[idx_q];
    sc_b = sofh_q[idx_q - 8'(lagk_q)];
    if (scal_q > 5'sh00) begin
      sc_a = mult_r(sc_a, 16'sh4000 >>> (scal_q - 5'sh01));
      sc_b = mult_r(sc_b, 16'sh4000 >>> (scal_q - 5'sh01));
    end
    prod = l_mult(sc_a, sc_b);
    acf_norm = norm32(acfh_q[0]);
    shifted = acfh_q[0] <<< acf_norm;
    abs_p1 = (p_q[1] == -16'sh8000) ? `VATD_MAX_Q15 : (p_q[1][15] ? -p_q[1] : p_q[1]);
    rc_now = div15(abs_p1, p_q[0]);
    if (p_q[1] > 16'sh0000) begin
      rc_now = -rc_now;
    end
  end

  // Pole frequency and prediction gain tests
  logic signed [15:0] a1_t, fa1, fa2, prederr;
  logic signed [31:0] l_den, l_num;
  logic pole_ok, tone_now;
  always_comb begin
    a1_t = rc_q[1] >>> 2;
    fa1 = add16(a1_t, mult_r(rc_q[2], a1_t));
    fa2 = rc_q[2] >>> 2;
    l_den = l_mult(fa1, fa1);
    l_num = l_sub({fa2, 16'h0000}, l_den);
    pole_ok = l_num > 32'sh0000_0000;
    if (fa1 < 16'sh0000 && l_sub(l_num, l_mult(l_den[31:16], FREQ_COEF)) < 32'sh0000_0000) begin
      pole_ok = 1'b0;
    end
    prederr = `VATD_MAX_Q15;
    for (int i = 1; i <= 4; i++) begin
      prederr = mult_t(prederr, add16(`VATD_MAX_Q15, -mult_t(rc_q[i], rc_q[i])));
    end
    tone_now = pole_ok && (add16(prederr, -`VATD_PRED_ERR_THR) < 16'sh0000);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= VATD_IDLE;
      flags <= '0;
      idx_q <= 8'h00;
      lagk_q <= 3'h0;
      seg_q <= 2'h0;
      n_q <= 3'h1;
      acc_q <= `VATD_RST_WORD;
      smax_q <= 16'sh0000;
      scal_q <= 5'sh00;
      oldlag_q <= `VATD_RST_LAG;
      {lagcount_q, oldlagcount_q, veryoldlagcount_q} <= 9'h000;
      rc_q <= '{default: 16'sh0000};
    end else begin
      flags.done <= 1'b0;
      flags.busy <= state_q != VATD_IDLE || start_wr;
      if (!downlink_q) begin
        flags.tone <= 1'b0;
      end
      case (state_q)
        VATD_IDLE: begin
          if (start_wr) begin
            state_q <= VATD_DECIDE;
          end
        end
        VATD_DECIDE: begin
          flags.activity <= ($signed(pv_exp_q) > $signed(th_exp_q)) ||
                            (pv_exp_q == th_exp_q && $signed(pv_mant_q) > $signed(th_mant_q));
          lagcount_q <= 3'h0;
          seg_q <= 2'h0;
          state_q <= VATD_PERIOD;
        end
        VATD_PERIOD: begin
          lagcount_q <= lagcount_q + 3'(lag_hit);
          oldlag_q <= cur_lag;
          seg_q <= seg_q + 2'h1;
          if (seg_q == `VATD_LAST_SUBSEG) begin
            state_q <= VATD_FEND;
          end
        end
        VATD_FEND: begin
          veryoldlagcount_q <= oldlagcount_q;
          oldlagcount_q <= lagcount_q;
          flags.periodicity <= 4'(oldlagcount_q) + 4'(lagcount_q) >= `VATD_PTCH_MIN;
          idx_q <= 8'h00;
          smax_q <= 16'sh0000;
          state_q <= downlink_q ? VATD_WIN : VATD_DONE;
        end
        VATD_WIN: begin
          sofh_q[idx_q] <= win_s;
          if (win_abs > smax_q) begin
            smax_q <= win_abs;
          end
          idx_q <= idx_q + 8'h01;
          if (idx_q == `VATD_LAST_SAMPLE) begin
            idx_q <= 8'h00;
            lagk_q <= 3'h0;
            acc_q <= `VATD_RST_WORD;
            state_q <= VATD_ACF;
            if (win_abs > smax_q) begin
              scal_q <= `VATD_SCALE_OFFSET - $signed(norm32({win_abs, 16'h0000}));
            end else begin
              scal_q <= (smax_q == 16'sh0000) ? 5'sh00 :
                        `VATD_SCALE_OFFSET - $signed(norm32({smax_q, 16'h0000}));
            end
          end
        end
        VATD_ACF: begin
          acc_q <= l_add(acc_q, prod);
          idx_q <= idx_q + 8'h01;
          if (idx_q == `VATD_LAST_SAMPLE) begin
            acfh_q[lagk_q] <= l_add(acc_q, prod);
            acc_q <= `VATD_RST_WORD;
            lagk_q <= lagk_q + 3'h1;
            idx_q <= 8'(lagk_q) + 8'h01;
            if (lagk_q == `VATD_ACF_LAST_LAG) begin
              state_q <= VATD_SINIT;
            end
          end
        end
        VATD_SINIT: begin
          // Same normalised start as the nine-term recursion
          for (int i = 0; i <= 4; i++) begin
            p_q[i] <= 16'((acfh_q[i] <<< acf_norm) >>> 16);
          end
          for (int i = 1; i <= 3; i++) begin
            k_q[5 - i] <= 16'((acfh_q[i] <<< acf_norm) >>> 16);
          end
          n_q <= 3'h1;
          rc_q <= '{default: 16'sh0000};
          state_q <= (shifted == 32'sh0000_0000) ? VATD_TONE : VATD_SCHUR;
        end
        VATD_SCHUR: begin
          if (p_q[0] < abs_p1) begin
            state_q <= VATD_TONE;
          end else begin
            rc_q[n_q] <= rc_now;
            n_q <= n_q + 3'h1;
            if (n_q == 3'h4) begin
              state_q <= VATD_TONE;
            end
            p_q[0] <= add16(p_q[0], mult_r(p_q[1], rc_now));
            for (int m = 1; m <= 3; m++) begin
              if (m <= 4 - int'(n_q)) begin
                p_q[m] <= add16(p_q[m + 1], mult_r(k_q[5 - m], rc_now));
                k_q[5 - m] <= add16(k_q[5 - m], mult_r(p_q[m + 1], rc_now));
              end
            end
          end
        end
        VATD_TONE: begin
          flags.tone <= downlink_q & tone_now;
          state_q <= VATD_DONE;
        end
        VATD_DONE: begin
          flags.done <= 1'b1;
          state_q <= VATD_IDLE;
        end
        default: state_q <= VATD_IDLE;
      endcase
    end
  end
endmodule

// ---- hw/vatd_map.svh ----
// Register offsets, reset values and fixed counts of the activity and tone detector
`ifndef VATD_MAP_SVH
`define VATD_MAP_SVH
`define VATD_OFF_CTRL 12'h000
`define VATD_OFF_STATUS 12'h004
`define VATD_OFF_PV_MANT 12'h008
`define VATD_OFF_PV_EXP 12'h00c
`define VATD_OFF_TH_MANT 12'h010
`define VATD_OFF_TH_EXP 12'h014
`define VATD_OFF_LAGS01 12'h018
`define VATD_OFF_LAGS23 12'h01c
`define VATD_OFF_AVG_SHIFT 12'h020
`define VATD_OFF_REF_SHIFT 12'h024
`define VATD_OFF_TEST_PARAM 12'h028
`define VATD_OFF_TEST_FLAGS 12'h02c
`define VATD_OFF_TEST_OUT 12'h030
`define VATD_OFF_OLD_LAG 12'h034
`define VATD_OFF_AVG_BASE 12'h040
`define VATD_OFF_REF_BASE 12'h080
`define VATD_OFF_SAMPLE_BASE 12'h400
`define VATD_CTRL_START_BIT 0
`define VATD_CTRL_DOWNLINK_BIT 1
`define VATD_CTRL_THR_UPDATE_BIT 2
`define VATD_TEST_FLAG_BIT 15
`define VATD_RST_WORD 32'h0000_0000
`define VATD_RST_LAG 16'h0000
`define VATD_RST_ADAPT 4'h0
`define VATD_ADAPT_LOAD 4'h9
`define VATD_PRED_TERMS 9
`define VATD_FRAME_LEN 160
`define VATD_LAST_SAMPLE 8'h9f
`define VATD_HALF_LEN 80
`define VATD_SUBSEGS 4
`define VATD_LAST_SUBSEG 2'h3
`define VATD_ACF_LAST_LAG 3'h4
`define VATD_MOD_PASSES 3
`define VATD_LAG_NEAR 16'sh0002
`define VATD_PTCH_MIN 4'h4
`define VATD_MAX_Q15 16'sh7fff
`define VATD_PRED_ERR_THR 16'sh05b8
`define VATD_SCALE_OFFSET 5'sh04
`define VATD_FREQ_COEF 16'sh0c75
`endif

// ---- hw/vatd_pkg.sv ----
// Types shared by the activity and tone detector
package vatd_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } vatd_wb_req_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic activity;
    logic tone;
    logic periodicity;
  } vatd_flags_t;
  typedef enum logic [3:0] {
    VATD_IDLE = 4'h0,
    VATD_DECIDE = 4'h1,
    VATD_PERIOD = 4'h3,
    VATD_FEND = 4'h2,
    VATD_WIN = 4'h6,
    VATD_ACF = 4'h7,
    VATD_SINIT = 4'h5,
    VATD_SCHUR = 4'h4,
    VATD_TONE = 4'hc,
    VATD_DONE = 4'hd
  } vatd_state_t;
endpackage

// ---- verification/vatd_core_asserts.sv ----
// Bus and flag checks for the activity and tone detector
`timescale 1ns/10ps
module vatd_core_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire vatd_pkg::vatd_wb_req_t wb_req,
  input wire logic [31:0] wb_rdata,
  input wire logic wb_ack,
  input wire vatd_pkg::vatd_flags_t flags
);
  import vatd_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic req;
  logic go;
  logic dl_q;
  assign req = wb_req.cyc && wb_req.stb && !wb_ack;
  assign go = req && wb_req.we && wb_req.adr == 12'h000 && wb_req.sel[0] && wb_req.dat[0]
    && !flags.busy;
  // Tracks the downlink bit so tone can be held against it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dl_q <= 1'b0;
    end else if (req && wb_req.we && wb_req.adr == 12'h000 && wb_req.sel[0]) begin
      dl_q <= wb_req.dat[1];
    end
  end
  ack_answer_a: assert property (req |=> wb_ack) else $error("no ack");
  ack_pulse_a: assert property (wb_ack |=> !wb_ack) else $error("long ack");
  busy_start_a: assert property (go |=> flags.busy) else $error("no busy");
  frame_time_a: assert property (go && !wb_req.dat[1] |-> ##8 flags.done)
    else $error("late done");
  done_pulse_a: assert property (flags.done |-> flags.busy ##1 !flags.done && !flags.busy)
    else $error("done shape");
  tone_uplink_a: assert property (!dl_q && !$past(dl_q) |-> !flags.tone)
    else $error("uplink tone");
  act_hold_a: assert property (!flags.busy && !$past(flags.busy) |-> $stable(flags.activity))
    else $error("activity moved");
  per_hold_a: assert property (!flags.busy && !$past(flags.busy)
    |-> $stable(flags.periodicity)) else $error("periodicity moved");
  cover property (flags.done && flags.activity);
  cover property (flags.periodicity);
  cover property (go && wb_req.dat[1]);
  cover property (flags.done && flags.tone);
endmodule
bind vatd_core vatd_core_asserts vatd_core_asserts_i (.mclk(mclk), .sys_rst(sys_rst),
  .wb_req(wb_req), .wb_rdata(wb_rdata), .wb_ack(wb_ack), .flags(flags));

// ---- verification/vatd_core_tb.sv ----
// Self-checking bench for the activity and tone detector
`timescale 1ns/10ps
module vatd_core_tb;
  import vatd_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  vatd_wb_req_t wb_req;
  logic [31:0] wb_rdata;
  logic wb_ack;
  vatd_flags_t flags;
  int err_count = 0;
  int checks = 0;
  logic [31:0] q;
  logic signed [15:0] old = 16'sh0000;
  logic [2:0] c1 = 3'h0;
  logic [2:0] c2 = 3'h0;
  always #2 mclk = ~mclk;
  vatd_core vatd_core_i (.mclk(mclk), .sys_rst(sys_rst), .wb_req(wb_req),
    .wb_rdata(wb_rdata), .wb_ack(wb_ack), .flags(flags));
  vatd_enc_model vatd_enc_model_i (.mclk(mclk), .wb_rdata(wb_rdata), .wb_ack(wb_ack),
    .wb_req(wb_req));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    vatd_enc_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    vatd_enc_model_i.xfer(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask
  task automatic close_out();
    $display("Mismatches %0d of %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Lag counts are folded here first, so the frame is judged on known values
  task automatic run(input logic [15:0] l [4], input logic dl);
    logic signed [15:0] mn, mx, s;
    int n;
    c2 = c1;
    c1 = 3'h0;
    for (int i = 0; i < 4; i++) begin
      mn = (old > $signed(l[i])) ? l[i] : old;
      mx = (old > $signed(l[i])) ? old : l[i];
      s = mx;
      for (int j = 0; j < 3; j++) begin
        if (s >= mn) s = s - mn;
      end
      if (mn - s < s) s = mn - s;
      if (s < 2) c1++;
      old = l[i];
    end
    vatd_enc_model_i.frame(l[0], l[1], l[2], l[3], dl);
    n = 0;
    while (flags.done !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    cmp({31'h0, flags.done}, 32'h1);
    @(posedge mclk);
    #1;
    vatd_enc_model_i.xfer(1'b0, 12'h004, 32'h0, q);
    cmp({29'h0, q[14:12]}, {29'h0, c1});
    cmp({29'h0, q[18:16]}, {29'h0, c2});
    cmp({31'h0, flags.periodicity}, {31'h0, {1'b0, c1} + c2 >= 4'h4});
    rd(12'h034, {16'h0, l[3]});
  endtask
  task automatic t_thr();
    for (int i = 0; i < 9; i++) wr(12'h040 + 12'(4 * i), 32'h1000 + 32'(i));
    wr(12'h020, 32'h15);
    wr(12'h000, 32'h4);
    for (int i = 0; i < 9; i++) rd(12'h080 + 12'(4 * i), 32'h1000 + 32'(i));
    rd(12'h024, 32'h15);
    vatd_enc_model_i.xfer(1'b0, 12'h004, 32'h0, q);
    cmp({28'h0, q[23:20]}, 32'h9);
  endtask
  // Exponent decides first; a negative exponent must lose
  task automatic t_act();
    logic [15:0] v [4][5];
    v = '{'{16'h5, 16'h100, 16'h4, 16'h7fff, 16'h1}, '{16'h4, 16'h201, 16'h4, 16'h200, 16'h1},
      '{16'h4, 16'h200, 16'h4, 16'h200, 16'h0}, '{16'hffff, 16'h7fff, 16'h1, 16'h100, 16'h0}};
    for (int k = 0; k < 4; k++) begin
      wr(12'h00c, {16'h0, v[k][0]});
      wr(12'h008, {16'h0, v[k][1]});
      wr(12'h014, {16'h0, v[k][2]});
      wr(12'h010, {16'h0, v[k][3]});
      run('{16'h29, 16'h43, 16'h5d, 16'h79}, 1'b0);
      cmp({31'h0, flags.activity}, {31'h0, v[k][4][0]});
    end
  endtask
  task automatic t_per();
    run('{16'h28, 16'h50, 16'h78, 16'h28}, 1'b0);
    run('{16'h32, 16'h64, 16'h32, 16'h96}, 1'b0);
    run('{16'h29, 16'h43, 16'h5d, 16'h79}, 1'b0);
  endtask
  // Silent frame gives no complex pole, so tone stays low
  task automatic t_tone();
    for (int i = 0; i < 160; i++) wr(12'h400 + 12'(4 * i), 32'h0);
    run('{16'h29, 16'h43, 16'h5d, 16'h79}, 1'b1);
    cmp({31'h0, flags.tone}, 32'h0);
    // Quarter-rate tone: even samples stay zero, so the first reflection is exactly zero
    for (int i = 1; i < 160; i += 2) wr(12'h400 + 12'(4 * i), i[1] ? 32'hf000 : 32'h1000);
    run('{16'h29, 16'h43, 16'h5d, 16'h79}, 1'b1);
    cmp({31'h0, flags.tone}, 32'h1);
    // Same strong tone in uplink must still read as no tone
    run('{16'h29, 16'h43, 16'h5d, 16'h79}, 1'b0);
    cmp({31'h0, flags.tone}, 32'h0);
  endtask
  task automatic t_test();
    for (int k = 0; k < 4; k++) begin
      wr(12'h028, 32'hd678_9234);
      wr(12'h02c, 32'(k));
      rd(12'h030, {k[1], 15'h5678, k[0], 15'h1234});
    end
    wr(12'h024, 32'h1f);
    rd(12'h024, 32'h15);
    rd(12'h038, 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(12'h004, 32'h0);
    t_thr();
    t_act();
    t_per();
    t_tone();
    t_test();
    close_out();
  end
  initial begin
    #200000;
    err_count++;
    close_out();
  end
endmodule

// ---- verification/vatd_enc_model.sv ----
// Encoder-side master that hands frame parameters to the detector
`timescale 1ns/10ps
module vatd_enc_model (
  input wire logic mclk,
  input wire logic [31:0] wb_rdata,
  input wire logic wb_ack,
  output vatd_pkg::vatd_wb_req_t wb_req
);
  import vatd_pkg::*;
  initial wb_req = '0;
  // Request stands until ack is sampled high; idles one cycle before the next
  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    // No limit of its own: the bench watchdog ends a hung transfer
    do begin
      @(posedge mclk);
    end while (wb_ack !== 1'b1);
    q = wb_rdata;
    wb_req <= '0;
  endtask
  // All four lags are in place before the start strobe
  task automatic frame(input logic [15:0] l0, l1, l2, l3, input logic dl);
    logic [31:0] q;
    xfer(1'b1, 12'h018, {l1, l0}, q);
    xfer(1'b1, 12'h01c, {l3, l2}, q);
    xfer(1'b1, 12'h000, {30'h0, dl, 1'b1}, q);
  endtask
endmodule
